// file: logic/fsp_pkg.sv
// Constants, types and register map of the flash access controller.
// Assumes a flash array macro that answers each request with a done pulse.
package fsp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADR_AREA = 8'hA7;
   localparam logic [7:0] ADR_OPC = 8'hF2;
   localparam logic [7:0] ADR_KEY0 = 8'hF3;
   localparam logic [7:0] ADR_KEY3 = 8'hF6;
   localparam logic [7:0] ADR_PAGE = 8'hF7;
   localparam logic [7:0] ADR_STAT = 8'hF9;
   localparam logic [7:0] ADR_OFFS = 8'hFB;
   localparam logic [7:0] ADR_DATA = 8'hFC;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int ST_BUSY = 0;
   localparam int ST_ABORT = 1;
   localparam int ST_MODE = 2;
   // ****************************************
   // Codes and sizes
   // ****************************************
   localparam logic [7:0] OPC_ERASE = 8'hE6;
   localparam logic [7:0] OPC_PROG = 8'h6E;
   localparam logic [15:0] KEY_SEQ = 16'h5A96;
   // Entry waveform on the four test pins, one nibble per step
   localparam logic [15:0] ENTRY_PAT = 16'hA5C3;
   localparam logic [2:0] LAST_STEP = 3'h4;
   localparam logic [7:0] BLANK = 8'hFF;
   localparam int MAX_SECT = 8;
   localparam int MAIN_SECT_BYTES = 1024;
   localparam int DATA_SECT_BYTES = 256;
   localparam int AW = 13;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      FL_READ = 3'b000,
      FL_PROG = 3'b001,
      FL_SERASE = 3'b010,
      FL_MERASE = 3'b011,
      FL_DERASE = 3'b100
   } fsp_flop_t;
   typedef enum logic [2:0] {
      IC_MERASE = 3'b000,
      IC_SERASE = 3'b001,
      IC_READ = 3'b010,
      IC_WRITE = 3'b011,
      IC_DERASE = 3'b100,
      IC_PROT = 3'b101
   } fsp_icmd_t;
   typedef struct packed {
      logic req;
      fsp_flop_t op;
      logic area;
      logic [AW-1:0] addr;
      logic [7:0] wdata;
   } fsp_fl_req_t;
   typedef struct packed {
      logic valid;
      fsp_icmd_t cmd;
      logic area;
      logic [AW-1:0] addr;
      logic [7:0] wdata;
   } fsp_icp_req_t;
   typedef struct packed {
      logic done;
      logic ok;
      logic [7:0] rdata;
   } fsp_icp_rsp_t;
endpackage : fsp_pkg

// file: logic/fsp_ctrl.sv
// Flash access controller: protection checks, self-programming registers,
// programmer entry detection. Assumes one clock and a flash macro port.
//
// Function
// (RULE1) Mode 0 blocks programmer access except mass erase
// (RULE2) Mode 1 blocks foreign code reads, self erase/write
// (RULE3) Protection bits change only through programmer path
// (RULE4) Mass erase ignores protection, clears protection bits
// (RULE5) Mass erase offered to programmer only
// (RULE6) Self erase/write needs mode 1 off
// (RULE7) Programmer erase/read/write needs mode 0 off
// (RULE8) Own executing sector always readable and writable
// (RULE9) Data area erase from both paths, unprotected
// (RULE10) Data byte read/write from both paths
// (RULE11) Programming mode only after pin waveform seen
// (RULE12) Self path never erases last main sector
// (RULE13) No reprogram of a byte before erase
// (RULE14) Wrong unlock keys abort self operation
// (RULE15) Page bits 7:2 sector, 1:0 offset high
// (RULE16) Data area: page bits 2:0 sector
// (RULE17) Offset register gives low eight address bits
// (RULE18) Data register holds byte to program
// (RULE19) Opcode E6 erases sector, 6E programs byte
// (RULE20) Software writes keys 5, A, 9, 6
// (RULE21) Opcode then four keys, strictly in order
// (RULE22) Area bit steers main or data area
// (RULE23) CPU held idle during self operation
// (RULE24) Broken order or refusal discards operation untouched
`timescale 1ns/10ps
module fsp_ctrl #(
   parameter int NUM_SECT = 8,
   parameter int DATA_SECT = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata_q,
   // CPU side
   input wire logic [2:0] i_exec_sec,
   input wire logic i_cr_req,
   input wire logic [fsp_pkg::AW-1:0] i_cr_addr,
   output logic o_cr_valid_q,
   output logic o_cr_ok_q,
   output logic o_cr_area_q,
   output logic o_hold_q,
   // Programmer side
   input wire logic [3:0] i_tp,
   input wire fsp_pkg::fsp_icp_req_t i_icp,
   output logic o_icp_ready_q,
   output fsp_pkg::fsp_icp_rsp_t o_icp_rsp_q,
   output logic o_icp_mode_q,
   // Flash macro
   output fsp_pkg::fsp_fl_req_t o_fl_q,
   input wire logic i_fl_done,
   input wire logic [7:0] i_fl_rdata
);
   import fsp_pkg::*;

   if (NUM_SECT < 2 || NUM_SECT > MAX_SECT || DATA_SECT < 1 || DATA_SECT > MAX_SECT) begin : g_chk
      $error("fsp_ctrl: sector counts out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHK = 2'b01,
      ST_RUN = 2'b10
   } fsp_st_t;

   fsp_st_t st_q;
   logic area_q;
   logic [7:0] opc_q, page_q, offs_q, data_q;
   logic [3:0] key_q [4];
   logic [2:0] step_q;
   logic abort_q;
   logic [MAX_SECT-1:0] prot0_q, prot1_q;
   logic job_icp_q, job_area_q;
   logic [AW-1:0] job_addr_q;
   logic [7:0] job_wdata_q;
   logic [3:0] tp_s1_q, tp_s2_q, tp_s3_q;
   logic [2:0] ent_q;
   logic [7:0] rd_mux;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [3:0] nib(input logic [15:0] w, input logic [1:0] i);
      return w[15 - 4 * i -: 4];
   endfunction : nib

   // Out of range sectors count as protected so they are always refused
   function automatic logic prot_hit(input logic [MAX_SECT-1:0] p, input logic [2:0] s);
      return ({1'b0, s} < 4'(NUM_SECT)) ? p[s] : 1'b1;
   endfunction : prot_hit

   function automatic fsp_fl_req_t mk_req(input fsp_flop_t op, input logic area,
                                          input logic [AW-1:0] a, input logic [7:0] d);
      fsp_fl_req_t r;
      r.req = 1'b1;
      r.op = op;
      r.area = area;
      r.addr = a;
      r.wdata = d;
      return r;
   endfunction : mk_req

   // ****************************************
   // Decode
   // ****************************************
   wire key_wr = i_wr && (i_addr >= ADR_KEY0) && (i_addr <= ADR_KEY3);
   wire [7:0] key_off = i_addr - ADR_KEY0;
   wire [1:0] kidx = key_off[1:0];
   wire key_good = key_wr && (step_q == 3'(kidx) + 3'h1)
                   && (i_wdata[3:0] == nib(KEY_SEQ, kidx)); // [RULE20] [RULE21]
   wire key_bad = key_wr && !key_good; // [RULE14]
   wire go_ssp = key_good && (kidx == 2'h3);

   wire is_prog = (opc_q == OPC_PROG); // [RULE19]
   wire is_erase = (opc_q == OPC_ERASE); // [RULE19]
   wire [5:0] msec = page_q[7:2]; // [RULE15]
   wire m_in = (msec < 6'(NUM_SECT));
   wire d_in = ({1'b0, page_q[2:0]} < 4'(DATA_SECT)); // [RULE16]
   wire p1_hit = prot_hit(prot1_q, page_q[4:2]);
   wire main_ok = m_in && (is_erase ? (!p1_hit && msec != 6'(NUM_SECT - 1)) // [RULE6] [RULE12]
                                     : (!p1_hit || page_q[4:2] == i_exec_sec)); // [RULE8]
   wire ssp_ok = (is_prog || is_erase) && (area_q ? d_in : main_ok); // [RULE22] [RULE9]
   wire [AW-1:0] ssp_addr = area_q ? {2'h0, page_q[2:0], offs_q} // [RULE16] [RULE17]
                                   : {page_q[4:0], offs_q}; // [RULE15]

   wire take_icp = i_icp.valid && o_icp_ready_q;
   wire launch = go_ssp && (st_q == ST_IDLE) && !take_icp && ssp_ok;
   wire blank_fail = (st_q == ST_CHK) && i_fl_done && (i_fl_rdata != BLANK); // [RULE13]
   wire [2:0] isec = i_icp.addr[12:10];
   wire p0_hit = !i_icp.area && prot_hit(prot0_q, isec);
   logic icp_ok;
   always_comb begin
      case (i_icp.cmd)
         IC_MERASE, IC_DERASE: icp_ok = 1'b1; // [RULE4] [RULE9]
         IC_SERASE, IC_READ, IC_WRITE: icp_ok = !p0_hit; // [RULE1] [RULE7] [RULE10]
         IC_PROT: icp_ok = ({1'b0, isec} < 4'(NUM_SECT));
         default: icp_ok = 1'b0;
      endcase
   end

   // ****************************************
   // Programmer entry detection
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tp_s1_q <= 4'h0;
         tp_s2_q <= 4'h0;
         tp_s3_q <= 4'h0;
      end else begin
         tp_s1_q <= i_tp;
         tp_s2_q <= tp_s1_q;
         tp_s3_q <= tp_s2_q;
      end
   end

   // Each agreed pin value is one step; a stray value restarts the match
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ent_q <= 3'h0;
         o_icp_mode_q <= 1'b0;
      end else if (!o_icp_mode_q && tp_s2_q == tp_s3_q
                   && tp_s3_q != nib(ENTRY_PAT, 2'(ent_q - 3'h1))) begin
         if (tp_s3_q == nib(ENTRY_PAT, ent_q[1:0])) begin
            ent_q <= ent_q + 3'h1;
            o_icp_mode_q <= (ent_q + 3'h1 == LAST_STEP); // [RULE11]
         end else begin
            ent_q <= (tp_s3_q == nib(ENTRY_PAT, 2'h0)) ? 3'h1 : 3'h0;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         area_q <= 1'b0;
         opc_q <= RST_BYTE;
         page_q <= RST_BYTE;
         offs_q <= RST_BYTE;
         data_q <= RST_BYTE;
         for (int i = 0; i < 4; i++) begin
            key_q[i] <= 4'h0;
         end
      end else if (i_wr) begin
         case (i_addr)
            ADR_AREA: area_q <= i_wdata[0]; // [RULE22]
            ADR_OPC: opc_q <= i_wdata;
            ADR_PAGE: page_q <= i_wdata;
            ADR_OFFS: offs_q <= i_wdata;
            ADR_DATA: data_q <= i_wdata; // [RULE18]
            default: begin
               if (key_wr) begin
                  key_q[kidx] <= i_wdata[3:0];
               end
            end
         endcase
      end
   end

   // Any key write out of order disarms; only the opcode write arms
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         step_q <= 3'h0;
      end else if (i_wr && i_addr == ADR_OPC) begin
         step_q <= 3'h1; // [RULE21]
      end else if (key_wr) begin
         step_q <= (key_good && kidx != 2'h3) ? step_q + 3'h1 : 3'h0; // [RULE14]
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         abort_q <= 1'b0;
      end else if (key_bad || (go_ssp && !launch) || (blank_fail && !job_icp_q)) begin
         abort_q <= 1'b1; // [RULE24]
      end else if (i_wr && i_addr == ADR_STAT && i_wdata[ST_ABORT]) begin
         abort_q <= 1'b0;
      end
   end

   always_comb begin
      case (i_addr)
         ADR_AREA: rd_mux = {7'h00, area_q};
         ADR_OPC: rd_mux = opc_q;
         ADR_PAGE: rd_mux = page_q;
         ADR_OFFS: rd_mux = offs_q;
         ADR_DATA: rd_mux = data_q;
         ADR_STAT: rd_mux = {5'h00, o_icp_mode_q, abort_q, st_q != ST_IDLE};
         default: rd_mux = key_wr || (i_addr >= ADR_KEY0 && i_addr <= ADR_KEY3)
                           ? {4'h0, key_q[kidx]} : RST_BYTE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata_q <= RST_BYTE;
      end else begin
         o_rdata_q <= i_rd ? rd_mux : RST_BYTE;
      end
   end

   // ****************************************
   // Protection bits
   // ****************************************
   // No register write reaches these; only accepted programmer commands
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prot0_q <= '0;
         prot1_q <= '0;
      end else if (take_icp && icp_ok) begin
         if (i_icp.cmd == IC_MERASE) begin
            prot0_q <= '0; // [RULE4]
            prot1_q <= '0;
         end else if (i_icp.cmd == IC_PROT) begin
            prot0_q[isec] <= prot0_q[isec] | i_icp.wdata[0]; // [RULE3]
            prot1_q[isec] <= prot1_q[isec] | i_icp.wdata[1];
         end
      end
   end

   // ****************************************
   // Code space reads
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cr_valid_q <= 1'b0;
         o_cr_ok_q <= 1'b0;
         o_cr_area_q <= 1'b0;
      end else begin
         o_cr_valid_q <= i_cr_req;
         o_cr_ok_q <= i_cr_req && (area_q || !prot_hit(prot1_q, i_cr_addr[12:10]) // [RULE2]
                      || i_cr_addr[12:10] == i_exec_sec); // [RULE8]
         o_cr_area_q <= area_q; // [RULE22]
      end
   end

   // ****************************************
   // Operation sequencer
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= ST_IDLE;
         o_fl_q <= '0;
         o_icp_rsp_q <= '0;
         o_icp_ready_q <= 1'b0;
         o_hold_q <= 1'b0;
         job_icp_q <= 1'b0;
         job_area_q <= 1'b0;
         job_addr_q <= '0;
         job_wdata_q <= RST_BYTE;
      end else begin
         o_fl_q.req <= 1'b0;
         o_icp_rsp_q.done <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               o_icp_ready_q <= o_icp_mode_q;
               if (take_icp) begin
                  job_icp_q <= 1'b1;
                  job_area_q <= i_icp.area;
                  job_addr_q <= i_icp.addr;
                  job_wdata_q <= i_icp.wdata;
                  if (!icp_ok || i_icp.cmd == IC_PROT) begin
                     o_icp_rsp_q <= '{done: 1'b1, ok: icp_ok, rdata: RST_BYTE}; // [RULE7]
                  end else begin
                     o_icp_ready_q <= 1'b0;
                     st_q <= ST_RUN;
                     case (i_icp.cmd)
                        IC_MERASE: o_fl_q <= mk_req(FL_MERASE, 1'b0, '0, BLANK); // [RULE5]
                        IC_SERASE: o_fl_q <= mk_req(FL_SERASE, i_icp.area, i_icp.addr, BLANK);
                        IC_DERASE: o_fl_q <= mk_req(FL_DERASE, 1'b1, '0, BLANK); // [RULE9]
                        IC_READ: o_fl_q <= mk_req(FL_READ, i_icp.area, i_icp.addr, BLANK);
                        default: begin
                           o_fl_q <= mk_req(FL_READ, i_icp.area, i_icp.addr, BLANK);
                           st_q <= ST_CHK; // [RULE13]
                        end
                     endcase
                  end
               end else if (launch) begin
                  job_icp_q <= 1'b0;
                  job_area_q <= area_q;
                  job_addr_q <= ssp_addr;
                  job_wdata_q <= data_q; // [RULE18]
                  o_icp_ready_q <= 1'b0;
                  o_hold_q <= 1'b1; // [RULE23]
                  if (is_prog) begin
                     o_fl_q <= mk_req(FL_READ, area_q, ssp_addr, data_q);
                     st_q <= ST_CHK; // [RULE13]
                  end else begin
                     o_fl_q <= mk_req(FL_SERASE, area_q, ssp_addr, BLANK); // [RULE6]
                     st_q <= ST_RUN;
                  end
               end
            end
            ST_CHK: begin
               if (i_fl_done) begin
                  if (blank_fail) begin
                     st_q <= ST_IDLE; // [RULE24]
                     o_hold_q <= 1'b0;
                     o_icp_rsp_q <= '{done: job_icp_q, ok: 1'b0, rdata: i_fl_rdata};
                  end else begin
                     o_fl_q <= mk_req(FL_PROG, job_area_q, job_addr_q, job_wdata_q);
                     st_q <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (i_fl_done) begin
                  st_q <= ST_IDLE;
                  o_hold_q <= 1'b0; // [RULE23]
                  o_icp_rsp_q <= '{done: job_icp_q, ok: 1'b1, rdata: i_fl_rdata};
               end
            end
            default: begin
               st_q <= ST_IDLE;
               o_hold_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   wire ssp_try = go_ssp && st_q == ST_IDLE && !take_icp && !area_q && page_q[7:5] == 3'h0;

   ssp_prot_erase_a: assert property (ssp_try && is_erase && prot1_q[page_q[4:2]] // [RULE6]
      |=> !o_fl_q.req && abort_q)
      else $error("self erase of protected sector issued");
   ssp_last_sec_a: assert property (ssp_try && is_erase && msec == 6'(NUM_SECT - 1) // [RULE12]
      |=> !o_fl_q.req && abort_q && st_q == ST_IDLE)
      else $error("self erase of last sector issued");
   ssp_own_sec_a: assert property (ssp_try && is_prog && page_q[4:2] == i_exec_sec // [RULE8]
      && m_in |=> o_fl_q.req && o_fl_q.op == FL_READ && o_hold_q)
      else $error("own sector write refused");
   ssp_addr_map_a: assert property (launch && !area_q // [RULE15]
      |=> o_fl_q.addr == {$past(page_q[4:0]), $past(offs_q)})
      else $error("main flash address mapped wrongly");
   icp_prot_block_a: assert property (take_icp && p0_hit && i_icp.cmd != IC_MERASE // [RULE1]
      && i_icp.cmd != IC_PROT && i_icp.cmd != IC_DERASE
      |=> o_icp_rsp_q.done && !o_icp_rsp_q.ok && !o_fl_q.req)
      else $error("programmer reached protected sector");
   mass_erase_a: assert property (take_icp && i_icp.cmd == IC_MERASE // [RULE4]
      |=> o_fl_q.req && o_fl_q.op == FL_MERASE && prot0_q == '0 && prot1_q == '0)
      else $error("mass erase not executed");
   mass_src_a: assert property (o_fl_q.req && o_fl_q.op == FL_MERASE // [RULE5]
      |-> $past(take_icp))
      else $error("mass erase from self path");
   prot_stable_a: assert property (!take_icp // [RULE3]
      |=> $stable(prot0_q) && $stable(prot1_q))
      else $error("protection changed without programmer");
   key_abort_a: assert property (key_bad |=> abort_q && step_q == 3'h0 ##1 abort_q) // [RULE14]
      else $error("bad key did not abort");
   blank_chk_a: assert property (blank_fail |=> !o_fl_q.req && st_q == ST_IDLE) // [RULE13]
      else $error("reprogram of written byte");
   cpu_hold_a: assert property (st_q != ST_IDLE && !job_icp_q |-> o_hold_q) // [RULE23]
      else $error("cpu not held during operation");
   entry_a: assert property ($rose(o_icp_mode_q) |-> $past(ent_q) == 3'h3) // [RULE11]
      else $error("programming mode without waveform");
   data_erase_a: assert property (take_icp && i_icp.cmd == IC_DERASE // [RULE9]
      |=> o_fl_q.req && o_fl_q.op == FL_DERASE)
      else $error("data area erase refused");

   cov_ssp_prog_c: cover property (launch && is_prog ##[1:20] st_q == ST_RUN);
   cov_ssp_erase_c: cover property (launch && is_erase);
   cov_icp_mass_c: cover property (take_icp && i_icp.cmd == IC_MERASE);
   cov_key_bad_c: cover property (key_bad);
endmodule : fsp_ctrl

// file: sim/fsp_flash_model.sv
// Flash array model on the controller's macro port.
// Assumes one-cycle request pulses; answers two cycles later with done.
`timescale 1ns/10ps
module fsp_flash_model
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Macro port
   input wire fsp_pkg::fsp_fl_req_t i_fl,
   output logic o_done,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:16383];
   fsp_fl_req_t pend_q;
   logic wait_q;
   logic [13:0] ix;
   initial begin
      for (int i = 0; i < 16384; i++) begin
         mem[i] = BLANK;
      end
   end
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_q <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_done <= 1'b0;
         // Stale data scrambled so nothing reads it by luck
         o_rdata <= ~o_rdata;
         if (i_fl.req) begin
            pend_q <= i_fl;
            wait_q <= 1'b1;
         end else if (wait_q) begin
            wait_q <= 1'b0;
            o_done <= 1'b1;
            o_rdata <= mem[{pend_q.area, pend_q.addr}];
            if (pend_q.op == FL_PROG) begin
               mem[{pend_q.area, pend_q.addr}] <= pend_q.wdata;
            end
            for (int i = 0; i < 16384; i++) begin
               ix = 14'(i);
               if ((pend_q.op == FL_MERASE && !ix[13]) || (pend_q.op == FL_DERASE && ix[13])
                   || (pend_q.op == FL_SERASE && ix[13] == pend_q.area && (pend_q.area ?
                   ix[10:8] == pend_q.addr[10:8] : ix[12:10] == pend_q.addr[12:10]))) begin
                  mem[i] <= BLANK;
               end
            end
         end
      end
   end
endmodule : fsp_flash_model

// file: sim/flash_self_program_protect_tb.sv
// Self-checking bench for the flash access controller.
// Assumes the flash array model answers on the macro port.
`timescale 1ns/10ps
module flash_self_program_protect_tb;
   import fsp_pkg::*;
   logic i_mclk, i_rst_n, i_wr, i_rd, i_cr_req, i_fl_done;
   logic o_cr_valid_q, o_cr_ok_q, o_cr_area_q, o_hold_q, o_icp_ready_q, o_icp_mode_q;
   logic [7:0] i_addr, i_wdata, o_rdata_q, i_fl_rdata;
   logic [2:0] i_exec_sec;
   logic [3:0] i_tp;
   logic [AW-1:0] i_cr_addr;
   fsp_icp_req_t i_icp;
   fsp_icp_rsp_t o_icp_rsp_q;
   fsp_fl_req_t o_fl_q;
   int n_fail, checked;
   fsp_ctrl dut (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_q, .i_exec_sec,
      .i_cr_req, .i_cr_addr, .o_cr_valid_q, .o_cr_ok_q, .o_cr_area_q, .o_hold_q, .i_tp, .i_icp,
      .o_icp_ready_q, .o_icp_rsp_q, .o_icp_mode_q, .o_fl_q, .i_fl_done, .i_fl_rdata);
   fsp_flash_model fl (.i_mclk, .i_rst_n, .i_fl(o_fl_q), .o_done(i_fl_done), .o_rdata(i_fl_rdata));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run;
      $display("checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic give_up(input string nm);
      chk(nm, 8'h01, 8'h00);
      complete_run();
   endtask : give_up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk(nm, exp, o_rdata_q);
   endtask : rdchk
   task automatic launch(input logic [7:0] opc, input logic [3:0] k1, input logic abt);
      int n;
      wr(ADR_OPC, opc);
      wr(ADR_KEY0, 8'h05);
      wr(8'hF4, {4'h0, k1});
      wr(8'hF5, 8'h09);
      wr(ADR_KEY3, 8'h06);
      // CPU idles until the operation ends
      for (n = 0; n < 200; n++) begin
         @(posedge i_mclk);
         #1;
         if (o_hold_q !== 1'b1) break;
      end
      if (n == 200) give_up("hold");
      rdchk("status", ADR_STAT, {5'h00, 1'b1, abt, 1'b0});
      if (abt) wr(ADR_STAT, 8'h02);
   endtask : launch
   task automatic in_circuit_programming(input fsp_icmd_t c, input logic ar, input logic [12:0] a,
                      input logic [7:0] d, input logic ok, input logic [7:0] exp);
      int n;
      @(posedge i_mclk);
      i_icp <= '{1'b1, c, ar, a, d};
      // Request stands until the edge that samples ready high
      for (n = 0; n < 100; n++) begin
         #1;
         if (o_icp_ready_q === 1'b1) break;
         @(posedge i_mclk);
      end
      if (n == 100) give_up("icp_ready");
      @(posedge i_mclk);
      i_icp.valid <= 1'b0;
      // A refusal answers at once, so look before the next edge
      for (n = 0; n < 100; n++) begin
         #1;
         if (o_icp_rsp_q.done === 1'b1) break;
         @(posedge i_mclk);
      end
      if (n == 100) give_up("icp_done");
      chk("icp_ok", {7'h00, ok}, {7'h00, o_icp_rsp_q.ok});
      if (c == IC_READ && ok) chk("icp_rdata", exp, o_icp_rsp_q.rdata);
   endtask : in_circuit_programming
   task automatic cr(input logic [12:0] a, input logic ok);
      @(posedge i_mclk);
      i_cr_req <= 1'b1;
      i_cr_addr <= a;
      @(posedge i_mclk);
      i_cr_req <= 1'b0;
      #1;
      chk("cr_ok", {7'h00, ok}, {7'h00, o_cr_ok_q & o_cr_valid_q});
   endtask : cr
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_regs;
      logic [7:0] adr [5] = '{ADR_OPC, ADR_PAGE, ADR_OFFS, ADR_DATA, 8'h80};
      for (int i = 0; i < 5; i++) begin
         rdchk("reset", adr[i], RST_BYTE);
         wr(adr[i], 8'hA5);
         rdchk("readback", adr[i], (i < 4) ? 8'hA5 : 8'h00);
      end
   endtask : s_regs
   task automatic s_entry;
      chk("mode", 8'h00, {7'h00, o_icp_mode_q});
      for (int k = 0; k < 4; k++) begin
         @(posedge i_mclk);
         i_tp <= ENTRY_PAT[15-4*k -: 4];
         repeat (6) @(posedge i_mclk);
      end
      #1;
      chk("mode", 8'h01, {7'h00, o_icp_mode_q});
   endtask : s_entry
   task automatic s_prog;
      wr(ADR_AREA, 8'h00);
      wr(ADR_PAGE, 8'h04);
      wr(ADR_OFFS, 8'h10);
      wr(ADR_DATA, 8'h5A);
      launch(OPC_PROG, 4'hA, 1'b0);
      in_circuit_programming(IC_READ, 1'b0, 13'h0410, 8'h00, 1'b1, 8'h5A);
      launch(OPC_PROG, 4'hA, 1'b1);
      launch(OPC_ERASE, 4'hB, 1'b1);
      launch(8'h00, 4'hA, 1'b1);
      in_circuit_programming(IC_READ, 1'b0, 13'h0410, 8'h00, 1'b1, 8'h5A);
      wr(ADR_PAGE, 8'h1C);
      launch(OPC_ERASE, 4'hA, 1'b1);
      wr(ADR_PAGE, 8'h04);
      launch(OPC_ERASE, 4'hA, 1'b0);
      in_circuit_programming(IC_READ, 1'b0, 13'h0410, 8'h00, 1'b1, BLANK);
   endtask : s_prog
   task automatic s_prot;
      in_circuit_programming(IC_PROT, 1'b0, 13'h0800, 8'h02, 1'b1, 8'h00);
      wr(ADR_PAGE, 8'h08);
      launch(OPC_PROG, 4'hA, 1'b1);
      cr(13'h0800, 1'b0);
      chk("cr_area", 8'h00, {7'h00, o_cr_area_q});
      @(posedge i_mclk);
      i_exec_sec <= 3'h2;
      launch(OPC_PROG, 4'hA, 1'b0);
      cr(13'h0800, 1'b1);
      @(posedge i_mclk);
      i_exec_sec <= 3'h0;
      in_circuit_programming(IC_PROT, 1'b0, 13'h0C00, 8'h01, 1'b1, 8'h00);
      in_circuit_programming(IC_READ, 1'b0, 13'h0C00, 8'h00, 1'b0, 8'h00);
      in_circuit_programming(IC_SERASE, 1'b0, 13'h0C00, 8'h00, 1'b0, 8'h00);
   endtask : s_prot
   task automatic s_data;
      wr(ADR_AREA, 8'h01);
      rdchk("area", ADR_AREA, 8'h01);
      cr(13'h0800, 1'b1);
      chk("cr_area", 8'h01, {7'h00, o_cr_area_q});
      wr(ADR_PAGE, 8'h01);
      wr(ADR_OFFS, 8'h20);
      wr(ADR_DATA, 8'hC3);
      launch(OPC_PROG, 4'hA, 1'b0);
      in_circuit_programming(IC_READ, 1'b1, 13'h0120, 8'h00, 1'b1, 8'hC3);
      launch(OPC_ERASE, 4'hA, 1'b0);
      in_circuit_programming(IC_READ, 1'b1, 13'h0120, 8'h00, 1'b1, BLANK);
      in_circuit_programming(IC_WRITE, 1'b1, 13'h0121, 8'h3C, 1'b1, 8'h00);
      in_circuit_programming(IC_MERASE, 1'b0, 13'h0000, 8'h00, 1'b1, 8'h00);
      in_circuit_programming(IC_READ, 1'b0, 13'h0810, 8'h00, 1'b1, BLANK);
      in_circuit_programming(IC_READ, 1'b0, 13'h0C00, 8'h00, 1'b1, BLANK);
      in_circuit_programming(IC_READ, 1'b1, 13'h0121, 8'h00, 1'b1, 8'h3C);
      in_circuit_programming(IC_DERASE, 1'b1, 13'h0000, 8'h00, 1'b1, 8'h00);
      in_circuit_programming(IC_READ, 1'b1, 13'h0121, 8'h00, 1'b1, BLANK);
   endtask : s_data
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_cr_req = 1'b0;
      i_cr_addr = '0;
      i_exec_sec = 3'h0;
      i_tp = 4'h0;
      i_icp = '0;
      n_fail = 0;
      checked = 0;
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      s_regs();
      s_entry();
      s_prog();
      s_prot();
      s_data();
      complete_run();
   end
endmodule : flash_self_program_protect_tb
